// File: uep_ep0_regs.sv
// Purpose: Endpoint-0 control, device address and USB event flags behind an APB slave.
// Assumes: Token, event and pin inputs are synchronous to pclk; tokens are one-cycle pulses.
// Notes:   pready is always high, so every APB transfer finishes in its first access cycle.
//
// Functional notes
// RQ1 - In byte count codes 9 to 15 behave as a count of eight.
// RQ2 - In NAK bit clear sends the packet; set means empty, IN gets NAK.
// RQ3 - Out NAK bit clear accepts OUT data; set means full, OUT gets NAK.
// RQ4 - Out transaction interrupt enable raises a request when an OUT completes.
// RQ5 - Stall bit answers STALL once, then hardware clears it.
// RQ6 - Out toggle bit is read-only and shows the current DATA0/DATA1 state.
// RQ7 - Buffer manager permit clear means endpoint 0 is not serviced.
// RQ8 - Address register holds seven address bits, bit 7 reads zero; tokens match it.
// RQ9 - Status flags are set by hardware, cleared only by writing one; function reset also clears every flag except bus reset.
// RQ10 - A set status flag with its mask bit raises the interrupt request.
// RQ11 - Setup overwrite flag sets when setup arrives while one is held.
// RQ12 - Remote wake flag sets on the wake input.
// RQ13 - Setup flag sets on SETUP; while set, endpoint-0 IN and OUT get NAK; with the stall and permit bits both set they get STALL.
// RQ14 - Rising edge on ring indicate sets the ring flag and requests wake.
// RQ15 - Resume flag sets when resume signalling is detected.
// RQ16 - Suspend flag sets on global or selective suspend.
// RQ17 - Bus reset flag sets on port reset; function reset leaves it alone.
// RQ18 - Endpoint-0 buffers sit at fixed addresses, out then in.
// RQ19 - Mask register uses the status bit positions and gates each flag.
// RQ20 - Accepted OUT loads count and sets out NAK; acknowledged IN sets in NAK.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module uep_ep0_regs
	import uep_pkg::*;
(
	input  wire logic              pclk,          // System clock, 25 MHz.
	input  wire logic              presetn,       // Power-up reset, asynchronous.
	input  wire logic              func_reset,    // USB function reset, synchronous.
	input  wire logic              psel,          // APB select.
	input  wire logic              penable,       // APB access phase.
	input  wire logic              pwrite,        // APB direction.
	input  wire logic [ADDR_W-1:0] paddr,         // APB byte address.
	input  wire logic [31:0]       pwdata,        // APB write data.
	output logic [31:0]            prdata,        // APB read data.
	output logic                   pready,        // APB ready.
	output logic                   pslverr,       // APB error on unmapped address.
	input  wire logic              tok_valid,     // Token received pulse.
	input  wire uep_token_t        tok_kind,      // Token kind.
	input  wire logic [6:0]        tok_addr,      // Token device address.
	input  wire logic [3:0]        tok_ep,        // Token endpoint.
	input  wire logic [3:0]        out_len,       // OUT data byte count.
	input  wire logic              out_pid_odd,   // OUT data was DATA1.
	input  wire logic              in_acked,      // Host acknowledged IN data.
	input  wire logic              wake_pin,      // Remote wakeup terminal.
	input  wire logic              ring_ind,      // Serial ring indicate.
	input  wire logic              resume_det,    // Resume signalling seen.
	input  wire logic              suspend_det,   // Suspend condition seen.
	input  wire logic              bus_reset_det, // Host port reset seen.
	output logic                   hs_valid,      // Answer pulse.
	output uep_hs_t                hs_code,       // Answer kind.
	output logic [3:0]             in_len,        // IN data byte count.
	output logic                   in_pid_odd,    // IN data is DATA1.
	output logic [15:0]            out_buf_base,  // Out buffer address.
	output logic [15:0]            in_buf_base,   // In buffer address.
	output logic                   out_xfer_irq,  // Out transaction done pulse.
	output logic                   event_irq,     // Event interrupt request.
	output logic                   wake_req       // Ring wake pulse.
);

	function automatic logic [3:0] clamp_count(input logic [3:0] raw);
		return (raw > CNT_MAX) ? CNT_MAX : raw;
	endfunction

	logic [7:0] in_cnt;
	logic [7:0] out_cnt;
	logic       permit;
	logic       stall;
	logic       irq_en;
	logic       out_tog;
	logic [6:0] dev_addr;
	logic [7:0] ev_status;
	logic [7:0] ev_mask;
	logic       ring_prev;
	logic       wake_prev;
	logic [15:0] reg_idx;
	logic       mapped;
	logic       wr;
	logic [7:0] wbyte;
	logic       hit;
	logic       ep0_busy_nak;
	logic       in_pending;
	logic [7:0] next_ev;
	logic [7:0] ev_set;
	logic [7:0] rd_val;

	////////////////////////////////////////////////////////////////////////////
	// APB decode. Registers answer without wait states.

	assign reg_idx = paddr[ADDR_W-1:2];
	assign wr      = psel && penable && pwrite;
	assign wbyte   = pwdata[7:0];
	assign pready  = 1'b1;

	always_comb begin
		mapped = 1'b1;
		rd_val = 8'h00;
		if (reg_idx == IDX_EP0_IN_BYTE_COUNT) begin
			rd_val = {in_cnt[CNT_NAK_BIT], 3'h0, in_cnt[3:0]};
		end else if (reg_idx == IDX_EP0_OUT_CONFIG) begin
			rd_val = {permit, 1'b0, out_tog, 1'b0, stall, irq_en, 2'h0}; // see RQ6
		end else if (reg_idx == IDX_EP0_OUT_BYTE_COUNT) begin
			rd_val = {out_cnt[CNT_NAK_BIT], 3'h0, out_cnt[3:0]};
		end else if (reg_idx == IDX_USB_EVENT_MASK) begin
			rd_val = ev_mask;
		end else if (reg_idx == IDX_USB_EVENT_STATUS) begin
			rd_val = ev_status;
		end else if (reg_idx == IDX_DEVICE_ADDRESS) begin
			rd_val = {1'b0, dev_addr}; // see RQ8
		end else begin
			mapped = 1'b0;
		end
	end

	assign pslverr = psel && penable && !mapped;

	// Read data is captured in the setup cycle so that it comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= {24'h00_0000, rd_val};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Token answer for endpoint 0.

	assign hit          = tok_valid && (tok_addr == dev_addr) && (tok_ep == EP0); // see RQ8
	assign ep0_busy_nak = !permit || ev_status[EV_SETUP]; // see RQ7, RQ13
	assign out_buf_base = EP0_OUT_BUF_BASE; // see RQ18
	assign in_buf_base  = EP0_IN_BUF_BASE; // see RQ18

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_valid   <= 1'b0;
			hs_code    <= UEP_HS_NAK;
			in_len     <= 4'h0;
			in_pid_odd <= 1'b0;
		end else begin
			hs_valid <= hit && !func_reset;
			if (hit) begin
				if (tok_kind == UEP_TOK_SETUP) begin
					hs_code <= UEP_HS_ACK;
				end else if (stall && permit) begin
					hs_code <= UEP_HS_STALL; // see RQ5
				end else if (ep0_busy_nak) begin
					hs_code <= UEP_HS_NAK; // see RQ7, RQ13
				end else if (tok_kind == UEP_TOK_IN) begin
					if (in_cnt[CNT_NAK_BIT]) begin
						hs_code <= UEP_HS_NAK; // see RQ2
					end else begin
						hs_code <= UEP_HS_DATA;
						in_len  <= clamp_count(in_cnt[3:0]); // see RQ1
					end
				end else if (out_cnt[CNT_NAK_BIT]) begin
					hs_code <= UEP_HS_NAK; // see RQ3
				end else begin
					hs_code <= UEP_HS_ACK;
				end
			end
			in_pid_odd <= out_tog;
		end
	end

	// An IN data packet is outstanding until the host acknowledges it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_pending <= 1'b0;
		end else if (func_reset) begin
			in_pending <= 1'b0;
		end else if (hit && tok_kind == UEP_TOK_IN && !(stall && permit) && !ep0_busy_nak
				&& !in_cnt[CNT_NAK_BIT]) begin
			in_pending <= 1'b1;
		end else if (in_acked) begin
			in_pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Endpoint-0 registers. Hardware updates win over a firmware write in the same cycle.

	logic out_accept;
	assign out_accept = hit && tok_kind == UEP_TOK_OUT && !(stall && permit) && !ep0_busy_nak
			&& !out_cnt[CNT_NAK_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_cnt <= BYTE_CNT_RESET;
		end else if (func_reset) begin
			in_cnt <= BYTE_CNT_RESET;
		end else if (in_pending && in_acked) begin
			in_cnt[CNT_NAK_BIT] <= 1'b1; // see RQ20
		end else if (wr && reg_idx == IDX_EP0_IN_BYTE_COUNT) begin
			in_cnt <= {wbyte[CNT_NAK_BIT], 3'h0, wbyte[3:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_cnt <= BYTE_CNT_RESET;
		end else if (func_reset) begin
			out_cnt <= BYTE_CNT_RESET;
		end else if (out_accept && out_pid_odd == out_tog) begin
			out_cnt <= {1'b1, 3'h0, clamp_count(out_len)}; // see RQ20, RQ3
		end else if (wr && reg_idx == IDX_EP0_OUT_BYTE_COUNT) begin
			out_cnt <= {wbyte[CNT_NAK_BIT], 3'h0, wbyte[3:0]};
		end
	end

	// A repeated packet with the stale toggle is acknowledged but not stored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_tog <= 1'b0;
		end else if (func_reset) begin
			out_tog <= 1'b0;
		end else if (hit && tok_kind == UEP_TOK_SETUP) begin
			out_tog <= 1'b1;
		end else if ((out_accept && out_pid_odd == out_tog) || (in_pending && in_acked)) begin
			out_tog <= !out_tog; // see RQ6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			permit <= 1'b0;
			irq_en <= 1'b0;
			stall  <= 1'b0;
		end else if (func_reset) begin
			permit <= 1'b0;
			irq_en <= 1'b0;
			stall  <= 1'b0;
		end else begin
			if (wr && reg_idx == IDX_EP0_OUT_CONFIG) begin
				permit <= wbyte[CFG_PERMIT_BIT];
				irq_en <= wbyte[CFG_IRQEN_BIT];
			end
			if (hit && tok_kind != UEP_TOK_SETUP && stall && permit) begin
				stall <= 1'b0; // see RQ5
			end else if (wr && reg_idx == IDX_EP0_OUT_CONFIG) begin
				stall <= wbyte[CFG_STALL_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_xfer_irq <= 1'b0;
		end else begin
			out_xfer_irq <= out_accept && out_pid_odd == out_tog && irq_en && !func_reset; // see RQ4
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_addr <= ADDR_RESET;
		end else if (func_reset) begin
			dev_addr <= ADDR_RESET;
		end else if (wr && reg_idx == IDX_DEVICE_ADDRESS) begin
			dev_addr <= wbyte[6:0]; // see RQ8
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event flags. A set in the same cycle as a write-one clear keeps the flag.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_prev <= 1'b0;
			wake_prev <= 1'b0;
			wake_req  <= 1'b0;
		end else begin
			ring_prev <= ring_ind;
			wake_prev <= wake_pin;
			wake_req  <= ring_ind && !ring_prev; // see RQ14
		end
	end

	always_comb begin
		ev_set                = 8'h00;
		ev_set[EV_SETUP_OVW]  = hit && tok_kind == UEP_TOK_SETUP && ev_status[EV_SETUP]; // see RQ11
		ev_set[EV_WAKE]       = wake_pin && !wake_prev; // see RQ12
		ev_set[EV_SETUP]      = hit && tok_kind == UEP_TOK_SETUP; // see RQ13
		ev_set[EV_RING]       = ring_ind && !ring_prev; // see RQ14
		ev_set[EV_RESUME]     = resume_det; // see RQ15
		ev_set[EV_SUSPEND]    = suspend_det; // see RQ16
		ev_set[EV_BUS_RESET]  = bus_reset_det; // see RQ17
		next_ev               = ev_status;
		if (wr && reg_idx == IDX_USB_EVENT_STATUS) begin
			next_ev = next_ev & ~wbyte; // see RQ9
		end
		if (func_reset) begin
			next_ev = next_ev & (8'h01 << EV_BUS_RESET); // see RQ17
		end
		next_ev = (next_ev | ev_set) & EV_IMPL_MASK; // see RQ9
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_status <= 8'h00;
		end else begin
			ev_status <= next_ev;
		end
	end

	// The reset-event enable survives a function reset, like its flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_mask <= 8'h00;
		end else if (wr && reg_idx == IDX_USB_EVENT_MASK) begin
			ev_mask <= wbyte & EV_IMPL_MASK; // see RQ19
		end else if (func_reset) begin
			ev_mask <= ev_mask & (8'h01 << EV_BUS_RESET);
		end
	end

	assign event_irq = |(ev_status & ev_mask); // see RQ10, RQ19

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_clean;
		!func_reset;
	endsequence

	sequence s_setup_tok;
		hit && tok_kind == UEP_TOK_SETUP && !func_reset;
	endsequence

	in_count_clamp_a: assert property (hs_valid && hs_code == UEP_HS_DATA |-> in_len <= CNT_MAX) // see RQ1
		else $error("in length above eight");
	in_nak_a: assert property ((hit && tok_kind == UEP_TOK_IN && in_cnt[CNT_NAK_BIT])
			and s_clean |=> hs_valid && hs_code != UEP_HS_DATA) // see RQ2
		else $error("IN served from empty buffer");
	out_nak_a: assert property ((hit && tok_kind == UEP_TOK_OUT && out_cnt[CNT_NAK_BIT]
			&& !(stall && permit)) and s_clean |=> hs_code == UEP_HS_NAK) // see RQ3
		else $error("OUT accepted into full buffer");
	xfer_irq_a: assert property (out_xfer_irq |-> $past(irq_en) && out_cnt[CNT_NAK_BIT]) // see RQ4
		else $error("transfer interrupt without enable");
	stall_clear_a: assert property ((hit && tok_kind != UEP_TOK_SETUP && stall && permit)
			and s_clean |=> hs_code == UEP_HS_STALL && !stall) // see RQ5
		else $error("stall not answered or not cleared");
	permit_nak_a: assert property ((hit && tok_kind != UEP_TOK_SETUP && !permit) and s_clean
			|=> hs_code == UEP_HS_NAK) // see RQ7
		else $error("endpoint serviced without permit");
	setup_nak_a: assert property ((ev_status[EV_SETUP] && hit && tok_kind != UEP_TOK_SETUP
			&& !(stall && permit)) and s_clean |=> hs_code == UEP_HS_NAK) // see RQ13
		else $error("endpoint 0 served while setup pending");
	setup_ovw_a: assert property (ev_status[EV_SETUP] ##0 s_setup_tok
			|=> ev_status[EV_SETUP_OVW]) // see RQ11
		else $error("setup overwrite not flagged");
	w1c_keep_a: assert property (wr && reg_idx == IDX_USB_EVENT_STATUS && !func_reset
			|=> (ev_status & ~$past(wbyte)) == ($past(ev_status) & ~$past(wbyte)
			& EV_IMPL_MASK) || $past(|ev_set)) // see RQ9
		else $error("write of zero altered a flag");
	bus_reset_keep_a: assert property (ev_status[EV_BUS_RESET] && func_reset
			&& !(wr && reg_idx == IDX_USB_EVENT_STATUS) |=> ev_status[EV_BUS_RESET]) // see RQ17
		else $error("function reset cleared bus reset flag");
	ring_edge_a: assert property ($rose(ring_ind) |=> ev_status[EV_RING] && wake_req) // see RQ14
		else $error("ring edge missed");
	irq_gate_a: assert property (ev_status[EV_SUSPEND] && ev_mask[EV_SUSPEND] |-> event_irq) // see RQ10
		else $error("masked-in flag gave no interrupt");
	addr_read_a: assert property (psel && !penable && reg_idx == IDX_DEVICE_ADDRESS
			|=> prdata[7] == 1'b0 && prdata[6:0] == $past(dev_addr)) // see RQ8
		else $error("address read wrong");

endmodule // uep_ep0_regs

// File: uep_pkg.sv
// Purpose: Shared constants and types for the endpoint-0 and USB event register block.
// Assumes: APB with 32-bit data; each register index is a word index (byte address = 4 x index).
// Notes:   Only the low eight bits of each register carry data; the rest read as zero.
package uep_pkg;

	localparam int unsigned ADDR_W = 18;

	// Register indices; byte address is four times the index.
	localparam logic [15:0] IDX_EP0_IN_BYTE_COUNT  = 16'hFF81;
	localparam logic [15:0] IDX_EP0_OUT_CONFIG     = 16'hFF82;
	localparam logic [15:0] IDX_EP0_OUT_BYTE_COUNT = 16'hFF83;
	localparam logic [15:0] IDX_USB_EVENT_MASK     = 16'hFFFD;
	localparam logic [15:0] IDX_USB_EVENT_STATUS   = 16'hFFFE;
	localparam logic [15:0] IDX_DEVICE_ADDRESS     = 16'hFFFF;

	// Fixed endpoint-0 buffer locations.
	localparam logic [15:0] EP0_OUT_BUF_BASE = 16'hFEF0;
	localparam logic [15:0] EP0_IN_BUF_BASE  = 16'hFEF8;

	// Field positions.
	localparam int unsigned CNT_NAK_BIT    = 7;
	localparam int unsigned CFG_PERMIT_BIT = 7;
	localparam int unsigned CFG_TOGGLE_BIT = 5;
	localparam int unsigned CFG_STALL_BIT  = 3;
	localparam int unsigned CFG_IRQEN_BIT  = 2;
	localparam int unsigned EV_SETUP_OVW   = 0;
	localparam int unsigned EV_WAKE        = 1;
	localparam int unsigned EV_SETUP       = 2;
	localparam int unsigned EV_RING        = 3;
	localparam int unsigned EV_RESUME      = 5;
	localparam int unsigned EV_SUSPEND     = 6;
	localparam int unsigned EV_BUS_RESET   = 7;

	// Implemented bits, reset values and count limits.
	localparam logic [7:0] EV_IMPL_MASK   = 8'hEF;
	localparam logic [3:0] CNT_MAX        = 4'h8;
	localparam logic [7:0] BYTE_CNT_RESET = 8'h80;
	localparam logic [6:0] ADDR_RESET     = 7'h00;
	localparam logic [3:0] EP0            = 4'h0;

	typedef enum logic [1:0] {UEP_TOK_SETUP, UEP_TOK_IN, UEP_TOK_OUT} uep_token_t;
	typedef enum logic [1:0] {UEP_HS_ACK, UEP_HS_NAK, UEP_HS_STALL, UEP_HS_DATA} uep_hs_t;

endpackage

// File: uep_host_model.sv
// Purpose: Behavioural USB host that issues endpoint tokens and acknowledges IN data.
// Assumes: The testbench calls one task at a time; fields change just after a rising edge.
// Notes:   Released token fields show the inverse of their last value.
`timescale 1ns/1ps
module uep_host_model
	import uep_pkg::*;
(
	input  wire logic pclk,        // System clock.
	output logic      tok_valid,   // Token pulse.
	output uep_token_t tok_kind,   // Token kind.
	output logic [6:0] tok_addr,   // Token address.
	output logic [3:0] tok_ep,     // Token endpoint.
	output logic [3:0] out_len,    // OUT byte count.
	output logic      out_pid_odd, // OUT data toggle.
	output logic      in_acked     // IN acknowledge.
);
	uep_token_t kind_q = UEP_TOK_IN;
	logic [6:0] addr_q = 7'h00;
	logic [3:0] ep_q   = 4'h0;
	logic [3:0] len_q  = 4'h0;
	logic       odd_q  = 1'b0;

	initial begin
		tok_valid = 1'b0;
		in_acked  = 1'b0;
	end

	// Stale fields never repeat the last token, so a late sample cannot match by luck.
	assign tok_kind    = tok_valid ? kind_q : uep_token_t'(~kind_q);
	assign tok_addr    = tok_valid ? addr_q : ~addr_q;
	assign tok_ep      = tok_valid ? ep_q : ~ep_q;
	assign out_len     = tok_valid ? len_q : ~len_q;
	assign out_pid_odd = tok_valid ? odd_q : ~odd_q;

	task automatic send(input uep_token_t k, input logic [6:0] a, input logic [3:0] e,
			input logic [3:0] l, input logic o);
		@(posedge pclk);
		tok_valid <= 1'b1;
		kind_q    <= k;
		addr_q    <= a;
		ep_q      <= e;
		len_q     <= l;
		odd_q     <= o;
		@(posedge pclk);
		tok_valid <= 1'b0;
	endtask

	// A delay argument lets the host acknowledge promptly or late.
	task automatic ack(input int dly);
		repeat (dly) @(posedge pclk);
		in_acked <= 1'b1;
		@(posedge pclk);
		in_acked <= 1'b0;
	endtask
endmodule // uep_host_model

// File: testbench.sv
// Purpose: Self-checking bench for the endpoint-0 and USB event register block.
// Assumes: APB answers whenever pready is high; tokens come from the host model.
// Notes:   Drivers queue expected results; a negedge monitor pops and compares them.
`timescale 1ns/1ps
module testbench
	import uep_pkg::*;
;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              tok_valid;
	uep_token_t        tok_kind;
	logic [6:0]        tok_addr;
	logic [3:0]        tok_ep;
	logic [3:0]        out_len;
	logic              out_pid_odd;
	logic              in_acked;
	logic [7:0]        ev_in;
	logic              hs_valid;
	uep_hs_t           hs_code;
	logic [3:0]        in_len;
	logic              in_pid_odd;
	logic [15:0]       out_buf_base;
	logic [15:0]       in_buf_base;
	logic              out_xfer_irq;
	logic              event_irq;
	logic              wake_req;
	logic [32:0]       rd_q[$];
	logic [5:0]        hs_q[$];
	logic [5:0]        e;
	int                mismatches = 0;
	int                checked = 0;
	int                irq_n = 0;
	int                wake_n = 0;
	int                rnd;
	int                b;
	logic [6:0]        addr;
	logic [3:0]        len;
	int                ev_bits[5] = '{1, 3, 5, 6, 7};
	logic [15:0]       rst_idx[6] = '{16'hFF81, 16'hFF82, 16'hFF83, 16'hFFFD, 16'hFFFE, 16'hFFFF};
	logic [7:0]        rst_val[6] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};

	uep_ep0_regs DUT (.pclk(pclk), .presetn(presetn), .func_reset(ev_in[0]), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tok_valid(tok_valid), .tok_kind(tok_kind),
		.tok_addr(tok_addr), .tok_ep(tok_ep), .out_len(out_len), .out_pid_odd(out_pid_odd),
		.in_acked(in_acked), .wake_pin(ev_in[1]), .ring_ind(ev_in[3]), .resume_det(ev_in[5]),
		.suspend_det(ev_in[6]), .bus_reset_det(ev_in[7]), .hs_valid(hs_valid),
		.hs_code(hs_code), .in_len(in_len), .in_pid_odd(in_pid_odd),
		.out_buf_base(out_buf_base), .in_buf_base(in_buf_base),
		.out_xfer_irq(out_xfer_irq), .event_irq(event_irq), .wake_req(wake_req));

	uep_host_model host (.pclk(pclk), .tok_valid(tok_valid), .tok_kind(tok_kind),
		.tok_addr(tok_addr), .tok_ep(tok_ep), .out_len(out_len),
		.out_pid_odd(out_pid_odd), .in_acked(in_acked));

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_word(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (mismatches == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
			input logic [32:0] exp);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, wd};
		if (!w) rd_q.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 33'h0);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b0, idx, 8'h00, {25'h0, d});
	endtask

	task automatic tok(input uep_token_t k, input logic [6:0] a, input logic [3:0] ep,
			input logic [3:0] l, input logic o, input logic ans, input uep_hs_t c);
		if (ans) hs_q.push_back({c, 4'h8});
		host.send(k, a, ep, l, o);
		repeat (2) @(posedge pclk);
	endtask

	task automatic pulse(input int bit_n);
		@(posedge pclk);
		ev_in[bit_n] <= 1'b1;
		@(posedge pclk);
		ev_in[bit_n] <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Sampling at the falling edge keeps the monitor clear of the design's own updates.
	always @(negedge pclk) begin
		if (presetn === 1'b1 && hs_valid === 1'b1) begin
			if (hs_q.size() == 0) cmp_word(33'h1, 33'h0);
			else begin
				e = hs_q.pop_front();
				cmp_word({27'h0, hs_code, (e[5:4] == UEP_HS_DATA) ? in_len : 4'h8}, {27'h0, e});
			end
		end
		if (psel && penable && !pwrite) cmp_word({pslverr, prdata}, rd_q.pop_front());
		if (out_xfer_irq === 1'b1) irq_n++;
		if (wake_req === 1'b1) wake_n++;
	end

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		test_done();
	end

	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = '0;
		pwdata  = 32'h0;
		ev_in   = 8'h00;
		rnd     = $urandom(32'hE2C8);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(rst_idx[i], rst_val[i]);
		apb(1'b0, 16'hFF80, 8'h00, {1'b1, 32'h0});
		cmp_word({17'h0, out_buf_base}, {17'h0, 16'hFEF0});
		cmp_word({17'h0, in_buf_base}, {17'h0, 16'hFEF8});
		addr = 7'($urandom_range(1, 126));
		wr(IDX_DEVICE_ADDRESS, {1'b1, addr});
		rd(IDX_DEVICE_ADDRESS, {1'b0, addr});
		tok(UEP_TOK_SETUP, addr ^ 7'h01, EP0, 4'h0, 1'b0, 1'b0, UEP_HS_ACK);
		tok(UEP_TOK_SETUP, addr, 4'h1, 4'h0, 1'b0, 1'b0, UEP_HS_ACK);
		wr(IDX_EP0_OUT_CONFIG, 8'hA4);
		rd(IDX_EP0_OUT_CONFIG, 8'h84);
		wr(IDX_EP0_IN_BYTE_COUNT, 8'h0C);
		wr(IDX_EP0_OUT_BYTE_COUNT, 8'h00);
		tok(UEP_TOK_SETUP, addr, EP0, 4'h0, 1'b0, 1'b1, UEP_HS_ACK);
		tok(UEP_TOK_IN, addr, EP0, 4'h0, 1'b0, 1'b1, UEP_HS_NAK);
		tok(UEP_TOK_OUT, addr, EP0, 4'h3, 1'b1, 1'b1, UEP_HS_NAK);
		tok(UEP_TOK_SETUP, addr, EP0, 4'h0, 1'b0, 1'b1, UEP_HS_ACK);
		rd(IDX_USB_EVENT_STATUS, 8'h05);
		wr(IDX_USB_EVENT_STATUS, 8'h00);
		rd(IDX_USB_EVENT_STATUS, 8'h05);
		wr(IDX_USB_EVENT_STATUS, 8'h05);
		rd(IDX_USB_EVENT_STATUS, 8'h00);
		rd(IDX_EP0_OUT_CONFIG, 8'hA4);
		tok(UEP_TOK_IN, addr, EP0, 4'h0, 1'b0, 1'b1, UEP_HS_DATA);
		@(negedge pclk);
		cmp_word({32'h0, in_pid_odd}, 33'h1);
		host.ack(3);
		rd(IDX_EP0_IN_BYTE_COUNT, 8'h8C);
		tok(UEP_TOK_IN, addr, EP0, 4'h0, 1'b0, 1'b1, UEP_HS_NAK);
		rd(IDX_EP0_OUT_CONFIG, 8'h84);
		len = 4'($urandom_range(0, 8));
		tok(UEP_TOK_OUT, addr, EP0, len, 1'b0, 1'b1, UEP_HS_ACK);
		rd(IDX_EP0_OUT_BYTE_COUNT, {4'h8, len});
		rd(IDX_EP0_OUT_CONFIG, 8'hA4);
		tok(UEP_TOK_OUT, addr, EP0, 4'h2, 1'b1, 1'b1, UEP_HS_NAK);
		cmp_word(33'(irq_n), 33'h1);
		wr(IDX_EP0_OUT_CONFIG, 8'h88);
		wr(IDX_EP0_OUT_BYTE_COUNT, 8'h00);
		tok(UEP_TOK_OUT, addr, EP0, 4'h2, 1'b1, 1'b1, UEP_HS_STALL);
		rd(IDX_EP0_OUT_CONFIG, 8'hA0);
		len = 4'($urandom_range(0, 8));
		tok(UEP_TOK_OUT, addr, EP0, len, 1'b1, 1'b1, UEP_HS_ACK);
		rd(IDX_EP0_OUT_BYTE_COUNT, {4'h8, len});
		cmp_word(33'(irq_n), 33'h1);
		wr(IDX_EP0_OUT_CONFIG, 8'h00);
		wr(IDX_EP0_OUT_BYTE_COUNT, 8'h00);
		wr(IDX_EP0_IN_BYTE_COUNT, 8'h01);
		tok(UEP_TOK_OUT, addr, EP0, 4'h1, 1'b0, 1'b1, UEP_HS_NAK);
		tok(UEP_TOK_IN, addr, EP0, 4'h0, 1'b0, 1'b1, UEP_HS_NAK);
		wr(IDX_USB_EVENT_MASK, 8'h48);
		rd(IDX_USB_EVENT_MASK, 8'h48);
		foreach (ev_bits[i]) begin
			b = ev_bits[i];
			pulse(b);
			rd(IDX_USB_EVENT_STATUS, 8'h01 << b);
			@(negedge pclk);
			cmp_word({32'h0, event_irq}, {32'h0, b == 3 || b == 6});
			wr(IDX_USB_EVENT_STATUS, ~(8'h01 << b));
			rd(IDX_USB_EVENT_STATUS, 8'h01 << b);
			wr(IDX_USB_EVENT_STATUS, 8'h01 << b);
			rd(IDX_USB_EVENT_STATUS, 8'h00);
		end
		cmp_word(33'(wake_n), 33'h1);
		tok(UEP_TOK_SETUP, addr, EP0, 4'h0, 1'b0, 1'b1, UEP_HS_ACK);
		pulse(EV_BUS_RESET);
		pulse(0);
		rd(IDX_USB_EVENT_STATUS, 8'h80);
		rd(IDX_DEVICE_ADDRESS, 8'h00);
		repeat (4) @(posedge pclk);
		cmp_word(33'(hs_q.size() + rd_q.size()), 33'h0);
		test_done();
	end
endmodule // testbench
